// ==== tw_bus_master.sv ====
// Bus master model that clocks transfers on the two-wire lines.
`timescale 1ns/100ps
module tw_bus_master #(parameter int HALF_NS = 250) (
    input wire logic scl_i, // Resolved clock line.
    input wire logic sda_i, // Resolved data line.
    output logic scl_lo, // High while the model pulls the clock low.
    output logic sda_lo // High while the model pulls the data low.
);
    initial begin
        scl_lo = 1'b0;
        sda_lo = 1'b0;
    end
    // One bit: data moves while the clock is low, sampled late in the high phase.
    task automatic bit_io(input logic d, output logic q);
        sda_lo = !d;
        #HALF_NS;
        scl_lo = 1'b0;
        wait (scl_i === 1'b1);
        #HALF_NS;
        q = sda_i;
        scl_lo = 1'b1;
    endtask : bit_io
    // A stalled clock just lengthens the wait above; the model never times out itself.
    task automatic start;
        wait (scl_i === 1'b1 && sda_i === 1'b1);
        sda_lo = 1'b1;
        #HALF_NS;
        scl_lo = 1'b1;
    endtask : start
    task automatic stop;
        sda_lo = 1'b1;
        #HALF_NS;
        scl_lo = 1'b0;
        wait (scl_i === 1'b1);
        #HALF_NS;
        sda_lo = 1'b0;
        #HALF_NS;
    endtask : stop
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic q;
        for (int i = 7; i >= 0; i--) bit_io(b[i], q);
        bit_io(1'b1, q);
        ack = !q;
    endtask : put_byte
    task automatic get_byte(output logic [7:0] b, input logic nak);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, q);
            b = {b[6:0], q};
        end
        bit_io(nak, q);
    endtask : get_byte
endmodule : tw_bus_master

// ==== tw_node.sv ====
// Two-wire bus node: addressed slave with byte handshakes and a small arbitrating master.
`timescale 1ns/100ps
module tw_node
    import tw_pkg::*;
(
    input wire logic clk, // System clock, 40 MHz.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic link_clk, // Clock of the bus-facing logic.
    input wire logic scl_i, // Clock line level.
    output logic scl_o, // Clock line drive value, always low.
    output logic scl_oe, // High while this node pulls the clock line low.
    input wire logic sda_i, // Data line level.
    output logic sda_o, // Data line drive value, always low.
    output logic sda_oe, // High while this node pulls the data line low.
    input wire logic [6:0] slave_addr, // Own address; change only while the bus is idle.
    output logic [7:0] received_byte_reg, // Last byte written by a master.
    output logic byte_received_flag, // A received byte waits for local logic.
    input wire logic rx_clear, // Pulse: received byte consumed.
    output logic read_in_progress_flag, // A master is reading from this node.
    input wire logic tx_load, // Pulse: load tx_byte into the transmit register.
    input wire logic [7:0] tx_byte, // Byte to send to a reading master.
    output logic [7:0] transmit_byte_reg, // Byte waiting to be sent.
    output logic tx_data_valid_flag, // Transmit register holds an unsent byte.
    output logic tx_data_request_flag, // A read is stalled waiting for data.
    input wire logic buf_enable, // Serve reads from the response buffer.
    input wire logic buf_wr, // Pulse: write one buffer entry.
    input wire logic [3:0] buf_addr, // Buffer entry to write.
    input wire logic [7:0] buf_wdata, // Buffer entry data.
    input wire logic m_start, // Pulse: probe an address as master.
    input wire logic [6:0] m_addr, // Address to probe.
    input wire logic m_read, // Direction bit sent with the address.
    output logic m_done, // Pulse: probe finished.
    output logic m_arb_lost, // Last probe lost arbitration.
    output logic m_nack, // Last probe was not acknowledged.
    output logic bus_busy // A start has been seen since the last stop.
);

    // ------------------------------------------------------------
    // Link clock domain: bus sampling, slave and master engines
    // ------------------------------------------------------------
    tw_link_s lr;
    tw_link_s l_nxt;
    tw_sys_s sr;
    tw_sys_s s_nxt;
    logic [7:0] resp_mem [TW_BUF_DEPTH];

    // Slave and master engines evaluate the synchronized lines each link cycle.
    always_comb begin
        logic scl_rise;
        logic scl_fall;
        logic start_det;
        logic stop_det;
        logic tx_avail;
        scl_rise = 1'b0;
        scl_fall = 1'b0;
        start_det = 1'b0;
        stop_det = 1'b0;
        tx_avail = 1'b0;
        l_nxt = lr;
        // Two stages before anything looks at the pins.
        l_nxt.scl_m1 = scl_i;
        l_nxt.scl_m2 = lr.scl_m1;
        l_nxt.sda_m1 = sda_i;
        l_nxt.sda_m2 = lr.sda_m1;
        l_nxt.scl_d = lr.scl_m2;
        l_nxt.sda_d = lr.sda_m2;
        l_nxt.ack_m1 = sr.ack_tgl;
        l_nxt.ack_m2 = lr.ack_m1;
        l_nxt.vld_m1 = sr.tx_vld;
        l_nxt.vld_m2 = lr.vld_m1;
        l_nxt.full_m1 = sr.rx_flag;
        l_nxt.full_m2 = lr.full_m1;
        l_nxt.cmd_m1 = sr.cmd_tgl;
        l_nxt.cmd_m2 = lr.cmd_m1;
        l_nxt.adr_m1 = slave_addr;
        l_nxt.adr_m2 = lr.adr_m1;
        scl_rise = lr.scl_m2 & ~lr.scl_d;
        scl_fall = ~lr.scl_m2 & lr.scl_d;
        start_det = lr.scl_m2 & lr.scl_d & lr.sda_d & ~lr.sda_m2;
        stop_det = lr.scl_m2 & lr.scl_d & ~lr.sda_d & lr.sda_m2;
        // A byte already taken stays unusable until the system side echoes the take.
        tx_avail = lr.vld_m2 & (lr.take_tgl == lr.ack_m2);

        // Bus free tracking.
        if (start_det) begin
            l_nxt.busy = 1'b1;
        end else if (stop_det) begin
            l_nxt.busy = 1'b0;
        end

        // Slave sequencer.
        if (start_det) begin
            // Also covers a repeated start in any state; the engine stays slave-ready.
            l_nxt.st = TW_S_ADDR;
            l_nxt.rd = 1'b0;
            l_nxt.bcnt = 4'h0;
            l_nxt.s_sda = 1'b0;
            l_nxt.s_scl = 1'b0;
            l_nxt.req = 1'b0;
        end else if (stop_det) begin
            l_nxt.st = TW_S_IDLE;
            l_nxt.rd = 1'b0;
            l_nxt.s_sda = 1'b0;
            l_nxt.s_scl = 1'b0;
            l_nxt.req = 1'b0;
        end else begin
            case (lr.st)
                TW_S_IDLE: begin
                    l_nxt.s_sda = 1'b0;
                    l_nxt.s_scl = 1'b0;
                end
                TW_S_ADDR, TW_S_RX: begin
                    if (scl_rise) begin
                        l_nxt.sh = {lr.sh[6:0], lr.sda_m2};
                        l_nxt.bcnt = lr.bcnt + 4'h1;
                    end else if (scl_fall && lr.bcnt == TW_BITS_PER_BYTE) begin
                        if (lr.st == TW_S_ADDR) begin
                            if (lr.sh[7:1] == lr.adr_m2) begin
                                l_nxt.rd = lr.sh[TW_RW_POS];
                                l_nxt.s_sda = 1'b1;
                                l_nxt.st = TW_S_AACK;
                            end else begin
                                l_nxt.st = TW_S_IDLE;
                            end
                        end else if (!lr.full_m2) begin
                            l_nxt.s_sda = 1'b1;
                            l_nxt.rx_data = lr.sh;
                            l_nxt.rx_tgl = ~lr.rx_tgl;
                            l_nxt.st = TW_S_RACK;
                        end else begin
                            // Previous byte not yet consumed: leave the slot high.
                            l_nxt.st = TW_S_IDLE;
                        end
                    end
                end
                TW_S_RACK: begin
                    if (scl_fall) begin
                        l_nxt.s_sda = 1'b0;
                        l_nxt.bcnt = 4'h0;
                        l_nxt.st = TW_S_RX;
                    end
                end
                TW_S_AACK, TW_S_TACK, TW_S_WAIT: begin
                    if (lr.st == TW_S_TACK && scl_rise) begin
                        l_nxt.rd = ~lr.sda_m2; // Acknowledged: keep reading.
                    end
                    if ((scl_fall && lr.st != TW_S_WAIT) || lr.st == TW_S_WAIT) begin
                        l_nxt.s_sda = 1'b0;
                        l_nxt.bcnt = 4'h0;
                        if (!lr.rd) begin
                            l_nxt.st = (lr.st == TW_S_AACK) ? TW_S_RX : TW_S_IDLE;
                        end else if (tx_avail) begin
                            l_nxt.sh = transmit_byte_reg;
                            l_nxt.take_tgl = ~lr.take_tgl;
                            l_nxt.s_sda = ~transmit_byte_reg[7];
                            l_nxt.s_scl = 1'b0;
                            l_nxt.req = 1'b0;
                            l_nxt.st = TW_S_TX;
                        end else begin
                            l_nxt.s_scl = 1'b1;
                            l_nxt.req = 1'b1;
                            l_nxt.st = TW_S_WAIT;
                        end
                    end
                end
                TW_S_TX: begin
                    if (scl_rise) begin
                        l_nxt.bcnt = lr.bcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (lr.bcnt == TW_BITS_PER_BYTE) begin
                            l_nxt.s_sda = 1'b0;
                            l_nxt.st = TW_S_TACK;
                        end else begin
                            l_nxt.sh = {lr.sh[6:0], 1'b0};
                            l_nxt.s_sda = ~lr.sh[6];
                        end
                    end
                end
                default: begin
                    l_nxt.st = TW_S_IDLE;
                end
            endcase
        end

        // Master probe: start, address byte, acknowledge, stop.
        case (lr.mst)
            TW_M_IDLE: begin
                l_nxt.m_scl = 1'b0;
                l_nxt.m_sda = 1'b0;
                if (lr.cmd_m2 != lr.cmd_seen && !lr.busy && !start_det) begin
                    l_nxt.cmd_seen = lr.cmd_m2;
                    l_nxt.m_sda = 1'b1;
                    l_nxt.mtim = 10'h000;
                    l_nxt.lost = 1'b0;
                    l_nxt.nack = 1'b0;
                    l_nxt.mst = TW_M_START;
                end
            end
            TW_M_START: begin
                l_nxt.mtim = lr.mtim + 10'h001;
                if (lr.mtim == TW_HIGH_CYC) begin
                    l_nxt.m_scl = 1'b1;
                    l_nxt.mbit = 4'h0;
                    l_nxt.mtim = 10'h000;
                    l_nxt.mst = TW_M_LOW;
                end
            end
            TW_M_LOW: begin
                l_nxt.m_scl = 1'b1;
                l_nxt.mtim = lr.mtim + 10'h001;
                if (lr.mbit < TW_BITS_PER_BYTE) begin
                    l_nxt.m_sda = ~lr.lost & ~sr.cmd_byte[3'(7 - lr.mbit)];
                end else if (lr.mbit == TW_ACK_BIT) begin
                    l_nxt.m_sda = 1'b0;
                end else begin
                    l_nxt.m_sda = 1'b1;
                end
                if (lr.mbit == TW_ACK_BIT && lr.lost) begin
                    // Lost: byte finished, withdraw and leave the rest to the winner.
                    l_nxt.m_scl = 1'b0;
                    l_nxt.m_sda = 1'b0;
                    l_nxt.done_tgl = ~lr.done_tgl;
                    l_nxt.mst = TW_M_IDLE;
                end else if (lr.mtim == TW_LOW_CYC) begin
                    l_nxt.m_scl = 1'b0;
                    l_nxt.mst = TW_M_HWAIT;
                end
            end
            TW_M_HWAIT: begin
                if (lr.scl_m2) begin
                    l_nxt.mtim = 10'h000;
                    l_nxt.mst = TW_M_HIGH;
                end
            end
            TW_M_HIGH: begin
                l_nxt.mtim = lr.mtim + 10'h001;
                if (lr.mbit < TW_BITS_PER_BYTE && !lr.m_sda && !lr.lost && !lr.sda_m2) begin
                    l_nxt.lost = 1'b1;
                    l_nxt.m_sda = 1'b0;
                end
                if (lr.mbit == TW_ACK_BIT && lr.mtim == 10'h000) begin
                    l_nxt.nack = lr.sda_m2;
                end
                if (lr.mbit == TW_STOP_BIT && lr.mtim == TW_HIGH_CYC) begin
                    l_nxt.m_sda = 1'b0;
                    l_nxt.done_tgl = ~lr.done_tgl;
                    l_nxt.mst = TW_M_IDLE;
                end else if (scl_fall || (lr.mtim == TW_HIGH_CYC && lr.mbit != TW_STOP_BIT)) begin
                    l_nxt.m_scl = 1'b1;
                    l_nxt.mtim = 10'h000;
                    l_nxt.mbit = lr.mbit + 4'h1;
                    l_nxt.mst = TW_M_LOW;
                end
            end
            default: begin
                l_nxt.mst = TW_M_IDLE;
            end
        endcase

        // Open-drain pins: low whenever either engine pulls.
        l_nxt.scl_oe = l_nxt.s_scl | l_nxt.m_scl;
        l_nxt.sda_oe = l_nxt.s_sda | l_nxt.m_sda;
        l_nxt.pin_lo = 1'b0;
    end

    // Link domain state register.
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            lr <= '0;
            lr.scl_m1 <= 1'b1;
            lr.scl_m2 <= 1'b1;
            lr.scl_d <= 1'b1;
            lr.sda_m1 <= 1'b1;
            lr.sda_m2 <= 1'b1;
            lr.sda_d <= 1'b1;
            lr.st <= TW_S_IDLE;
            lr.mst <= TW_M_IDLE;
        end else begin
            lr <= l_nxt;
        end
    end

    // ------------------------------------------------------------
    // System clock domain: flags, data registers, response buffer
    // ------------------------------------------------------------

    // Handshake side of each crossing, plus the local flag handling.
    always_comb begin
        logic rx_evt;
        logic take_evt;
        rx_evt = 1'b0;
        take_evt = 1'b0;
        s_nxt = sr;
        s_nxt.rxt_m1 = lr.rx_tgl;
        s_nxt.rxt_m2 = sr.rxt_m1;
        s_nxt.rxt_d = sr.rxt_m2;
        s_nxt.rd_m1 = lr.rd;
        s_nxt.rd_m2 = sr.rd_m1;
        s_nxt.rq_m1 = lr.req;
        s_nxt.rq_m2 = sr.rq_m1;
        s_nxt.tk_m1 = lr.take_tgl;
        s_nxt.tk_m2 = sr.tk_m1;
        s_nxt.tk_d = sr.tk_m2;
        s_nxt.dn_m1 = lr.done_tgl;
        s_nxt.dn_m2 = sr.dn_m1;
        s_nxt.dn_d = sr.dn_m2;
        s_nxt.bz_m1 = lr.busy;
        s_nxt.bz_m2 = sr.bz_m1;
        rx_evt = sr.rxt_m2 ^ sr.rxt_d;
        take_evt = sr.tk_m2 ^ sr.tk_d;

        // Received byte: the data word is stable long before its toggle lands.
        if (rx_evt) begin
            s_nxt.rx_byte = lr.rx_data;
            s_nxt.rx_flag = 1'b1;
        end else if (rx_clear) begin
            s_nxt.rx_flag = 1'b0;
        end

        // Transmit register: a new load wins over the take of the old byte.
        if (take_evt) begin
            s_nxt.tx_vld = 1'b0;
            s_nxt.ack_tgl = sr.tk_m2;
        end
        if (!sr.rd_m2) begin
            s_nxt.bidx = 4'h0;
        end
        if (tx_load) begin
            s_nxt.tx_byte = tx_byte;
            s_nxt.tx_vld = 1'b1;
        end else if (buf_enable && !sr.tx_vld && !take_evt && sr.rd_m2) begin
            // Feed the next stored response entry, wrapping after sixteen.
            s_nxt.tx_byte = resp_mem[sr.bidx];
            s_nxt.tx_vld = 1'b1;
            s_nxt.bidx = sr.bidx + 4'h1;
        end

        // Master probe command and result.
        s_nxt.m_done = 1'b0;
        if (m_start && sr.cmd_tgl == sr.dn_m2) begin
            s_nxt.cmd_byte = {m_addr, m_read};
            s_nxt.cmd_tgl = ~sr.cmd_tgl;
        end
        if (sr.dn_m2 ^ sr.dn_d) begin
            s_nxt.m_done = 1'b1;
            s_nxt.m_lost = lr.lost;
            s_nxt.m_nack = lr.nack;
        end
    end

    // System domain state register.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sr <= '0;
        end else begin
            sr <= s_nxt;
        end
    end

    // Response buffer; only the array itself, no reset needed.
    always_ff @(posedge clk) begin
        if (buf_wr) begin
            resp_mem[buf_addr] <= buf_wdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs, each straight from a flip-flop
    // ------------------------------------------------------------
    assign scl_o = lr.pin_lo;
    assign sda_o = lr.pin_lo;
    assign scl_oe = lr.scl_oe;
    assign sda_oe = lr.sda_oe;
    assign received_byte_reg = sr.rx_byte;
    assign byte_received_flag = sr.rx_flag;
    assign read_in_progress_flag = sr.rd_m2;
    assign transmit_byte_reg = sr.tx_byte;
    assign tx_data_valid_flag = sr.tx_vld;
    assign tx_data_request_flag = sr.rq_m2;
    assign m_done = sr.m_done;
    assign m_arb_lost = sr.m_lost;
    assign m_nack = sr.m_nack;
    assign bus_busy = sr.bz_m2;

endmodule : tw_node

// ==== tw_node_props.sv ====
// Port checker for the two-wire bus node.
`timescale 1ns/100ps
module tw_node_props (
    input wire logic clk, // System clock.
    input wire logic rstn, // Reset, active low.
    input wire logic link_clk, // Link clock.
    input wire logic scl_i, // Clock line level.
    input wire logic scl_o, // Clock drive value.
    input wire logic scl_oe, // Clock pull enable.
    input wire logic sda_o, // Data drive value.
    input wire logic sda_oe, // Data pull enable.
    input wire logic byte_received_flag, // Receive flag.
    input wire logic rx_clear, // Receive flag clear.
    input wire logic read_in_progress_flag, // Read flag.
    input wire logic tx_load, // Transmit load.
    input wire logic [7:0] tx_byte, // Transmit data.
    input wire logic [7:0] transmit_byte_reg, // Transmit register.
    input wire logic tx_data_valid_flag, // Transmit valid.
    input wire logic tx_data_request_flag, // Transmit request.
    input wire logic m_done, // Probe finished.
    input wire logic bus_busy // Bus busy.
);
    // Open-drain pins may only pull low; a high drive would fight the pull-up.
    pin_low_a: assert property (@(posedge link_clk) disable iff (!rstn) !scl_o && !sda_o)
        else $error("line drive value not low");
    ack_hold_a: assert property (@(posedge link_clk) disable iff (!rstn)
        $rose(scl_i) && sda_oe |=> sda_oe [*8]) else $error("data low dropped in clock high");
    start_free_a: assert property (@(posedge link_clk) disable iff (!rstn)
        $rose(sda_oe) && scl_i |-> !bus_busy) else $error("start on busy bus");
    rx_rise_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(byte_received_flag) |-> !read_in_progress_flag) else $error("receive during read");
    rx_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        $fell(byte_received_flag) |-> $past(rx_clear)) else $error("receive flag fell alone");
    tx_load_a: assert property (@(posedge clk) disable iff (!rstn)
        tx_load |=> tx_data_valid_flag && transmit_byte_reg == $past(tx_byte)) else $error("load lost");
    tx_take_a: assert property (@(posedge clk) disable iff (!rstn)
        $fell(tx_data_valid_flag) |-> read_in_progress_flag) else $error("valid dropped outside read");
    stall_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(tx_data_request_flag) |-> scl_oe && !tx_data_valid_flag) else $error("request without stall");
    // Main scenarios reached.
    cover property (@(posedge clk) $rose(byte_received_flag));
    cover property (@(posedge clk) $rose(tx_data_request_flag));
    cover property (@(posedge clk) m_done);
endmodule : tw_node_props

bind tw_node tw_node_props i_props (.clk(clk), .rstn(rstn), .link_clk(link_clk), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .byte_received_flag(byte_received_flag),
    .rx_clear(rx_clear), .read_in_progress_flag(read_in_progress_flag), .tx_load(tx_load),
    .tx_byte(tx_byte), .transmit_byte_reg(transmit_byte_reg), .tx_data_valid_flag(tx_data_valid_flag),
    .tx_data_request_flag(tx_data_request_flag), .m_done(m_done), .bus_busy(bus_busy));

// ==== tw_node_tb.sv ====
// Testbench: local side of the node plus a bus master model on the lines.
`timescale 1ns/100ps
module tw_node_tb;
    import tw_pkg::*;
    logic clk = 0, rstn = 0, link_clk = 0, rx_clear = 0, tx_load = 0, m_start = 0, m_read = 0, ben = 0, bwr = 0;
    logic [7:0] tx_byte = 8'h00, bwd = 8'h00;
    logic [6:0] m_addr = 7'h13;
    logic scl_oe, sda_oe, p_scl, p_sda, flag, rip, vld, req, mdone, mlost, mnack, busy, ack;
    logic [7:0] rxb, txr, b;
    wire logic scl = !(scl_oe || p_scl);
    wire logic sda = !(sda_oe || p_sda);
    int fails = 0, n_tests = 0;
    initial forever #12.5 clk = ~clk;
    initial begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    tw_node i_dut (.clk(clk), .rstn(rstn), .link_clk(link_clk), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .slave_addr(7'h2A), .received_byte_reg(rxb),
        .byte_received_flag(flag), .rx_clear(rx_clear), .read_in_progress_flag(rip), .tx_load(tx_load),
        .tx_byte(tx_byte), .transmit_byte_reg(txr), .tx_data_valid_flag(vld), .tx_data_request_flag(req),
        .buf_enable(ben), .buf_wr(bwr), .buf_addr(4'h0), .buf_wdata(bwd), .m_start(m_start),
        .m_addr(m_addr), .m_read(m_read), .m_done(mdone), .m_arb_lost(mlost), .m_nack(mnack), .bus_busy(busy));
    tw_bus_master i_bus (.scl_i(scl), .sda_i(sda), .scl_lo(p_scl), .sda_lo(p_sda));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wrap_up;
        $display("fails=%0d n_tests=%0d", fails, n_tests);
        if (fails == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    // Whole write transfer; the data byte is skipped when the address is refused.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ea, input logic ed);
        i_bus.start();
        i_bus.put_byte(a, ack);
        chk(ack, ea);
        if (ack) begin
            i_bus.put_byte(d, ack);
            chk(ack, ed);
        end
        i_bus.stop();
    endtask : wr
    task automatic load(input logic [7:0] d);
        @(posedge clk) tx_load <= 1'b1;
        tx_byte <= d;
        @(posedge clk) tx_load <= 1'b0;
    endtask : load
    // The whole run is under two hundred microseconds; this cuts a hang short.
    initial begin
        #1000000;
        fails++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        wr(8'h54, 8'hA5, 1'b1, 1'b1);
        chk(rxb, 8'hA5);
        chk(flag, 8'h01);
        chk(rip, 8'h00);
        wr(8'h54, 8'h3C, 1'b1, 1'b0);
        chk(rxb, 8'hA5);
        @(posedge clk) rx_clear <= 1'b1;
        @(posedge clk) rx_clear <= 1'b0;
        @(negedge clk) chk(flag, 8'h00);
        wr(8'h56, 8'h00, 1'b0, 1'b0);
        load(8'h3C);
        @(negedge clk) chk(txr, 8'h3C);
        i_bus.start();
        i_bus.put_byte(8'h55, ack);
        chk(ack, 8'h01);
        i_bus.get_byte(b, 1'b0);
        chk(b, 8'h3C);
        chk(rip, 8'h01);
        fork
            i_bus.get_byte(b, 1'b1);
            begin
                for (int i = 0; i < 400 && req !== 1'b1; i++) @(negedge clk);
                chk(req, 8'h01);
                chk(scl, 8'h00);
                chk(busy, 8'h01);
                load(8'h81);
            end
        join
        chk(b, 8'h81);
        i_bus.stop();
        chk(sda, 8'h01);
        @(posedge clk) {ben, bwr, bwd} <= {2'b11, 8'h6E};
        @(posedge clk) bwr <= 1'b0;
        i_bus.start();
        i_bus.put_byte(8'h55, ack);
        i_bus.get_byte(b, 1'b1);
        chk(b, 8'h6E);
        i_bus.stop();
        repeat (20) @(negedge clk);
        chk(busy, 8'h00);
        @(posedge clk) m_start <= 1'b1;
        m_read <= 1'b1;
        @(posedge clk) m_start <= 1'b0;
        for (int i = 0; i < 8000 && mdone !== 1'b1; i++) @(negedge clk);
        chk(mdone, 8'h01);
        chk(mnack, 8'h01);
        chk(mlost, 8'h00);
        wrap_up();
    end
endmodule : tw_node_tb

// ==== tw_pkg.sv ====
// Constants, state types and carrier structs for the two-wire bus node.
// Operation
// - Transmitter releases data line during acknowledge pulse
// - Receiver holds data low through acknowledge high
// - Unmatched address leaves acknowledge slot high
// - Receiver unable to take more bytes not-acknowledges
// - Slave-transmitter releases data after master not-acknowledge
// - Sample data while clock high, change while low
// - Each falling clock edge restarts own low timing
// - Released clock waits high-wait until line rises
// - Shortest high period ends the shared clock high
// - Start only when bus seen free
// - Driving high but seeing low loses arbitration
// - Arbitration checked over address, data and acknowledge (the master checks only the eight address bits)
// - Loser clocks to end of byte, then withdraws
// - Loser in address phase keeps slave operation
// - Stops and repeated starts share frame position
// - Respond only to the configured slave address
// - Readable response buffer holds sixteen entries
// - Written byte lands in register, receive flag set
// - Loaded valid byte is sent on next read
// - No valid data: request flag, hold clock low
// - Start and stop are data edges with clock high
// - Eight bits, most significant first, then acknowledge
package tw_pkg;

    // ------------------------------------------------------------
    // Timing of the master clock, counted on the link clock
    // ------------------------------------------------------------
    localparam int TW_LINK_PERIOD_PS = 6000;
    localparam int TW_T_LOW_PS = 4700000;
    localparam int TW_T_HIGH_PS = 4000000;
    localparam logic [9:0] TW_LOW_CYC = 10'((TW_T_LOW_PS + TW_LINK_PERIOD_PS - 1) / TW_LINK_PERIOD_PS);
    localparam logic [9:0] TW_HIGH_CYC = 10'((TW_T_HIGH_PS + TW_LINK_PERIOD_PS - 1) / TW_LINK_PERIOD_PS);

    // ------------------------------------------------------------
    // Frame layout and buffer size
    // ------------------------------------------------------------
    localparam logic [3:0] TW_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TW_ACK_BIT = 4'h8;
    localparam logic [3:0] TW_STOP_BIT = 4'h9;
    localparam int TW_BUF_DEPTH = 16;
    localparam int TW_RW_POS = 0;

    // Slave sequencer, Gray coded along the usual path.
    typedef enum logic [2:0] {
        TW_S_IDLE = 3'b000,
        TW_S_ADDR = 3'b001,
        TW_S_AACK = 3'b011,
        TW_S_RX = 3'b010,
        TW_S_RACK = 3'b110,
        TW_S_TX = 3'b111,
        TW_S_TACK = 3'b101,
        TW_S_WAIT = 3'b100
    } tw_slave_e;

    // Master clock generator, Gray coded from idle through to high; high back to low flips two bits.
    typedef enum logic [2:0] {
        TW_M_IDLE = 3'b000,
        TW_M_START = 3'b001,
        TW_M_LOW = 3'b011,
        TW_M_HWAIT = 3'b010,
        TW_M_HIGH = 3'b110
    } tw_master_e;

    // State of the logic that runs on the link clock.
    typedef struct packed {
        logic scl_m1;
        logic scl_m2;
        logic scl_d;
        logic sda_m1;
        logic sda_m2;
        logic sda_d;
        logic busy;
        tw_slave_e st;
        logic [3:0] bcnt;
        logic [7:0] sh;
        logic rd;
        logic s_scl;
        logic s_sda;
        logic scl_oe;
        logic sda_oe;
        logic pin_lo;
        logic rx_tgl;
        logic [7:0] rx_data;
        logic take_tgl;
        logic ack_m1;
        logic ack_m2;
        logic vld_m1;
        logic vld_m2;
        logic full_m1;
        logic full_m2;
        logic cmd_m1;
        logic cmd_m2;
        logic cmd_seen;
        logic [6:0] adr_m1;
        logic [6:0] adr_m2;
        logic req;
        tw_master_e mst;
        logic [3:0] mbit;
        logic [9:0] mtim;
        logic m_scl;
        logic m_sda;
        logic lost;
        logic nack;
        logic done_tgl;
    } tw_link_s;

    // State of the logic that runs on the system clock.
    typedef struct packed {
        logic rxt_m1;
        logic rxt_m2;
        logic rxt_d;
        logic [7:0] rx_byte;
        logic rx_flag;
        logic rd_m1;
        logic rd_m2;
        logic rq_m1;
        logic rq_m2;
        logic [7:0] tx_byte;
        logic tx_vld;
        logic tk_m1;
        logic tk_m2;
        logic tk_d;
        logic ack_tgl;
        logic cmd_tgl;
        logic [7:0] cmd_byte;
        logic dn_m1;
        logic dn_m2;
        logic dn_d;
        logic m_done;
        logic m_lost;
        logic m_nack;
        logic bz_m1;
        logic bz_m2;
        logic [3:0] bidx;
    } tw_sys_s;

endpackage : tw_pkg
